// ### verification/qbs_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module qbs_ctrl_model (
	input  wire logic        sys_clk,
	input  wire logic        clk_run,
	output logic             in_clk_p,
	output logic             in_clk_n,
	output logic             read_port_select_n,
	output logic             write_port_select_n,
	output logic [19:0]      addr,
	output logic [17:0]      wdata,
	output logic [1:0]       byte_write_select_n
);
	int          edge_cnt = 0;
	logic        pr_n [1024] = '{default: 1'b1};
	logic        pw_n [1024] = '{default: 1'b1};
	logic        va   [1024] = '{default: 1'b0};
	logic        vd   [1024] = '{default: 1'b0};
	logic [19:0] pa   [1024];
	logic [17:0] pd   [1024];
	logic [1:0]  pb   [1024];

	// Link clock stands still between tests, its edges landing on sys_clk falling edges
	initial begin
		in_clk_p = 1'b0;
		in_clk_n = 1'b0;
		read_port_select_n = 1'b1;
		write_port_select_n = 1'b1;
		addr = 20'h00000;
		wdata = 18'h00000;
		byte_write_select_n = 2'h3;
		#7;
		forever begin
			wait (clk_run);
			#160;
			edge_cnt++;
			in_clk_p = ~in_clk_p;
			in_clk_n = ~in_clk_p;
		end
	end

	// Inputs change mid half-cycle so they are stable around every link rise
	always @(posedge in_clk_p or posedge in_clk_n) begin
		repeat (2) @(negedge sys_clk);
		read_port_select_n <= pr_n[edge_cnt + 1];
		write_port_select_n <= pw_n[edge_cnt + 1];
		// Released lines show the inverse of their last value
		addr <= va[edge_cnt + 1] ? pa[edge_cnt + 1] : ~addr;
		wdata <= vd[edge_cnt + 1] ? pd[edge_cnt + 1] : ~wdata;
		byte_write_select_n <= vd[edge_cnt + 1] ? pb[edge_cnt + 1] : ~byte_write_select_n;
	end
endmodule
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        sys_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        pll_disable_n = 1'b1;
	logic        clk_run = 1'b0;
	logic        clk_p, clk_n, rps_n, wps_n, oe, vflag, echo_p, echo_n;
	logic [19:0] addr;
	logic [17:0] wdata, rdata;
	logic [1:0]  bws_n;
	logic [19:0] obs [1024];
	logic [1:0]  ep [1024];
	logic [71:0] ref_mem [int];
	int          q_e [$];
	logic [71:0] q_d [$];
	int          num_errors = 0, tests_run = 0, cycles = 0, out_edge = 0, lat = 5;

	always #20 sys_clk = ~sys_clk;

	qbs_ctrl_model i_ctrl (
		.sys_clk(sys_clk), .clk_run(clk_run), .in_clk_p(clk_p), .in_clk_n(clk_n),
		.read_port_select_n(rps_n), .write_port_select_n(wps_n), .addr(addr),
		.wdata(wdata), .byte_write_select_n(bws_n)
	);

	qbs_sram_ports i_dut (
		.sys_clk(sys_clk), .resetn(resetn), .in_clk_p(clk_p), .in_clk_n(clk_n),
		.pll_disable_n(pll_disable_n), .read_port_select_n(rps_n),
		.write_port_select_n(wps_n), .addr(addr), .wdata(wdata),
		.byte_write_select_n(bws_n), .rdata(rdata), .rdata_oe(oe),
		.read_data_valid_flag(vflag), .echo_clock_out(echo_p), .echo_clock_out_n(echo_n)
	);

	// Echo edge k mirrors link rise k; sample while the word is settled
	always @(posedge echo_p or posedge echo_n) begin
		out_edge++;
		repeat (2) @(negedge sys_clk);
		obs[out_edge] = {oe, vflag, rdata};
		ep[out_edge] = {echo_p, echo_n};
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			wrap_up();
		end
	end

	task chk(input logic [19:0] seen, input logic [19:0] want);
		tests_run++;
		if (seen !== want) begin
			num_errors++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	function automatic int base();
		return i_ctrl.edge_cnt + 3 - (i_ctrl.edge_cnt % 2);
	endfunction

	task wr(input int e, input logic [19:0] a, input logic [71:0] d, input logic [7:0] b);
		i_ctrl.pw_n[e] = 1'b0;
		i_ctrl.pa[e] = a;
		i_ctrl.va[e] = 1'b1;
		for (int i = 0; i < 4; i++) begin
			i_ctrl.pd[e + 2 + i] = d[18 * i +: 18];
			i_ctrl.pb[e + 2 + i] = b[2 * i +: 2];
			i_ctrl.vd[e + 2 + i] = 1'b1;
			for (int h = 0; h < 2; h++)
				if (!b[2 * i + h])
					ref_mem[a][18 * i + 9 * h +: 9] = d[18 * i + 9 * h +: 9];
		end
	endtask

	task rd(input int e, input logic [19:0] a);
		i_ctrl.pr_n[e] = 1'b0;
		i_ctrl.pa[e] = a;
		i_ctrl.va[e] = 1'b1;
		q_e.push_back(e);
		q_d.push_back(ref_mem[a]);
	endtask

	// Runs the link for n rises, then judges every planned read
	task go(input int n);
		int          t, e;
		logic [71:0] d;
		t = i_ctrl.edge_cnt + n;
		clk_run = 1'b1;
		while (i_ctrl.edge_cnt < t)
			@(negedge sys_clk);
		clk_run = 1'b0;
		repeat (12) @(negedge sys_clk);
		while (q_e.size() > 0) begin
			e = q_e.pop_front();
			d = q_d.pop_front();
			chk({1'b0, obs[e + lat - 1][18], 18'h00000}, 20'h40000);
			chk({18'h00000, ep[e + lat]}, ((e + lat) % 2) ? 20'h00002 : 20'h00001);
			for (int i = 0; i < 4; i++)
				chk(obs[e + lat + i] & 20'hBFFFF, {2'h2, d[18 * i +: 18]});
		end
	endtask

	task t_basic();
		int e;
		e = base();
		wr(e, 20'h00001, 72'h123456789ABCDEF012, 8'h00);
		rd(e + 2, 20'h00001);
		rd(e + 6, 20'h00001);
		go(30);
		chk({1'b0, obs[e + lat][18], 18'h00000}, 20'h00000);
		chk({1'b0, obs[e + 9 + lat][18], 18'h00000}, 20'h00000);
		chk({obs[e + 10 + lat][19], 19'h00000}, 20'h00000);
		$display("test basic done");
	endtask

	task t_mask();
		int e;
		e = base();
		wr(e, 20'h00002, 72'hFEDCBA9876543210AB, 8'h00);
		wr(e + 4, 20'h00002, 72'h555555555555555555, 8'h39);
		rd(e + 8, 20'h00002);
		go(24);
		$display("test mask done");
	endtask

	task t_refuse();
		int e;
		e = base();
		wr(e, 20'h00004, 72'h0F0F0F0F0F0F0F0F0F, 8'h00);
		i_ctrl.pw_n[e + 2] = 1'b0;
		i_ctrl.pa[e + 2] = 20'h00001;
		i_ctrl.va[e + 2] = 1'b1;
		rd(e + 8, 20'h00004);
		i_ctrl.pr_n[e + 10] = 1'b0;
		i_ctrl.pa[e + 10] = 20'h00002;
		i_ctrl.va[e + 10] = 1'b1;
		i_ctrl.pr_n[e + 15] = 1'b0;
		rd(e + 20, 20'h00001);
		go(36);
		for (int k = e + 12 + lat; k < e + 20 + lat; k++)
			chk({obs[k][19], 19'h00000}, 20'h00000);
		$display("test refuse done");
	endtask

	task t_both();
		int e;
		e = base();
		rd(e, 20'h00004);
		i_ctrl.pw_n[e] = 1'b0;
		wr(e + 2, 20'h00005, 72'hC3C3C3C3C3C3C3C3C3, 8'h00);
		i_ctrl.pr_n[e + 2] = 1'b0;
		rd(e + 4, 20'h00005);
		i_ctrl.pw_n[e + 4] = 1'b0;
		go(24);
		$display("test both done");
	endtask

	task t_legacy();
		int e;
		pll_disable_n = 1'b0;
		lat = 2;
		repeat (4) @(negedge sys_clk);
		e = base();
		rd(e, 20'h00002);
		wr(e + 2, 20'h00006, 72'h9A9A9A9A9A9A9A9A9A, 8'h00);
		rd(e + 4, 20'h00006);
		go(20);
		$display("test legacy done");
	endtask

	task wrap_up();
		$display("checks=%0d mismatches=%0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (10) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (4) @(negedge sys_clk);
		t_basic();
		t_mask();
		t_refuse();
		t_both();
		t_legacy();
		wrap_up();
	end
endmodule
`default_nettype wire

// ### verilog/qbs_pkg.sv
package qbs_pkg;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 18;
	localparam int HALF_W = 9;
	localparam int BURST = 4;
	localparam int IDX_W = 2;
	localparam int DEPTH = 1 << ADDR_W;
	localparam int BWS_W = 2;
	localparam int BWS_LO = 0;
	localparam int BWS_HI = 1;
	localparam int LAT_MAX = 5;
	localparam int LAT_PLL = 5;
	localparam int LAT_LEGACY = 2;
	localparam logic [2:0] TAP_PLL = 3'(LAT_PLL - 1);
	localparam logic [2:0] TAP_LEGACY = 3'(LAT_LEGACY - 1);
	localparam int LEGACY_MAX_MHZ = 167;
	localparam logic [IDX_W-1:0] IDX_FIRST = 2'h0;
	localparam logic [IDX_W-1:0] IDX_LAST = 2'h3;
	typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} qbs_op_e;
endpackage

// ### verilog/qbs_sram_ports.sv
`timescale 1ns/1ps
`default_nettype none
module qbs_sram_ports (
	input  wire logic                        sys_clk,
	input  wire logic                        resetn,
	input  wire logic                        in_clk_p,
	input  wire logic                        in_clk_n,
	input  wire logic                        pll_disable_n,
	input  wire logic                        read_port_select_n,
	input  wire logic                        write_port_select_n,
	input  wire logic [qbs_pkg::ADDR_W-1:0]  addr,
	input  wire logic [qbs_pkg::DATA_W-1:0]  wdata,
	input  wire logic [qbs_pkg::BWS_W-1:0]   byte_write_select_n,
	output logic      [qbs_pkg::DATA_W-1:0]  rdata,
	output logic                             rdata_oe,
	output logic                             read_data_valid_flag,
	output logic                             echo_clock_out,
	output logic                             echo_clock_out_n
);
	localparam int SW = 5 + qbs_pkg::ADDR_W + qbs_pkg::DATA_W + qbs_pkg::BWS_W;

	logic [SW-1:0]                 s_bus;
	logic                          kp_s;
	logic                          kn_s;
	logic                          pll_s;
	logic                          rps_s;
	logic                          wps_s;
	logic [qbs_pkg::ADDR_W-1:0]    a_s;
	logic [qbs_pkg::DATA_W-1:0]    d_s;
	logic [qbs_pkg::BWS_W-1:0]     bws_s;
	logic                          kp_d_ff;
	logic                          kn_d_ff;
	logic                          k_rise;
	logic                          kn_rise;
	logic                          edge_any;
	logic                          acc_rd;
	logic                          acc_wr;
	qbs_pkg::qbs_op_e              last_op_ff;
	logic [qbs_pkg::LAT_MAX-1:0]   stg_v_ff;
	logic [qbs_pkg::ADDR_W-1:0]    stg_a_ff [qbs_pkg::LAT_MAX];
	logic [2:0]                    tap_i;
	logic                          tap_v;
	logic [qbs_pkg::ADDR_W-1:0]    tap_a;
	logic                          rd_busy_ff;
	logic [qbs_pkg::IDX_W-1:0]     rd_i_ff;
	logic [qbs_pkg::ADDR_W-1:0]    rd_a_ff;
	logic [qbs_pkg::ADDR_W-1:0]    f_a;
	logic [qbs_pkg::IDX_W-1:0]     f_i;
	logic [qbs_pkg::DATA_W-1:0]    f_w;
	logic [qbs_pkg::DATA_W-1:0]    q_int_ff;
	logic                          q_on_ff;
	logic                          req_on_ff;
	logic [qbs_pkg::ADDR_W-1:0]    req_a_ff;
	logic                          col_on_ff;
	logic [qbs_pkg::IDX_W-1:0]     col_i_ff;
	logic [qbs_pkg::ADDR_W-1:0]    col_a_ff;
	logic [qbs_pkg::DATA_W-1:0]    col_d_ff [qbs_pkg::BURST];
	logic [qbs_pkg::BWS_W-1:0]     col_m_ff [qbs_pkg::BURST];
	logic                          cap_first;
	logic                          cap;
	logic [qbs_pkg::IDX_W-1:0]     cap_i;
	logic                          commit;
	logic [qbs_pkg::DATA_W-1:0]    cm_d [qbs_pkg::BURST];
	logic [qbs_pkg::BWS_W-1:0]     cm_m [qbs_pkg::BURST];
	logic [qbs_pkg::HALF_W-1:0]    mem_lo [qbs_pkg::BURST][qbs_pkg::DEPTH];
	logic [qbs_pkg::DATA_W-qbs_pkg::HALF_W-1:0] mem_hi [qbs_pkg::BURST][qbs_pkg::DEPTH];

	// Every pin but sys_clk and resetn, the link clocks included, crosses through the same two stages
	qbs_sync #(
		.W(SW)
	) u_sync (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.din     ({in_clk_p, in_clk_n, pll_disable_n, read_port_select_n,
			write_port_select_n, addr, wdata, byte_write_select_n}),
		.dout_ff (s_bus)
	);

	assign {kp_s, kn_s, pll_s, rps_s, wps_s, a_s, d_s, bws_s} = s_bus;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			kp_d_ff <= 1'b0;
			kn_d_ff <= 1'b0;
		end else begin
			kp_d_ff <= kp_s;
			kn_d_ff <= kn_s;
		end
	end

	assign k_rise = kp_s & ~kp_d_ff;
	assign kn_rise = kn_s & ~kn_d_ff;
	assign edge_any = k_rise | kn_rise;

	// Port selects looked at on positive rises only
	always_comb begin
		acc_rd = 1'b0;
		acc_wr = 1'b0;
		if (k_rise) begin
			if (!rps_s && !wps_s) begin
				if (last_op_ff == qbs_pkg::OP_READ) begin
					acc_wr = 1'b1;
				end else begin
					acc_rd = 1'b1;
				end
			end else begin
				acc_rd = !rps_s && (last_op_ff != qbs_pkg::OP_READ);
				acc_wr = !wps_s && (last_op_ff != qbs_pkg::OP_WRITE);
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			last_op_ff <= qbs_pkg::OP_IDLE;
		end else if (k_rise) begin
			if (acc_rd) begin
				last_op_ff <= qbs_pkg::OP_READ;
			end else if (acc_wr) begin
				last_op_ff <= qbs_pkg::OP_WRITE;
			end else begin
				last_op_ff <= qbs_pkg::OP_IDLE;
			end
		end
	end

	// Read requests travel one stage per clock rise until their latency is spent
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			stg_v_ff <= '0;
			for (int i = 0; i < qbs_pkg::LAT_MAX; i++) begin
				stg_a_ff[i] <= '0;
			end
		end else if (edge_any) begin
			stg_v_ff <= {stg_v_ff[qbs_pkg::LAT_MAX-2:0], acc_rd};
			stg_a_ff[0] <= a_s;
			for (int i = 1; i < qbs_pkg::LAT_MAX; i++) begin
				stg_a_ff[i] <= stg_a_ff[i-1];
			end
		end
	end

	// Mode is meant to be static; only the tap moves with it
	assign tap_i = pll_s ? qbs_pkg::TAP_PLL : qbs_pkg::TAP_LEGACY;
	assign tap_v = stg_v_ff[tap_i];
	assign tap_a = stg_a_ff[tap_i];

	// Word fetch, with words of the burst still being collected forwarded
	always_comb begin
		f_a = tap_v ? tap_a : rd_a_ff;
		f_i = tap_v ? qbs_pkg::IDX_FIRST : qbs_pkg::IDX_W'(rd_i_ff + 1'b1);
		f_w = {mem_hi[f_i][f_a], mem_lo[f_i][f_a]};
		if (col_on_ff && (col_a_ff == f_a) && (f_i < col_i_ff)) begin
			if (!col_m_ff[f_i][qbs_pkg::BWS_LO]) begin
				f_w[qbs_pkg::HALF_W-1:0] = col_d_ff[f_i][qbs_pkg::HALF_W-1:0];
			end
			if (!col_m_ff[f_i][qbs_pkg::BWS_HI]) begin
				f_w[qbs_pkg::DATA_W-1:qbs_pkg::HALF_W] =
					col_d_ff[f_i][qbs_pkg::DATA_W-1:qbs_pkg::HALF_W];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			rd_busy_ff <= 1'b0;
			rd_i_ff <= qbs_pkg::IDX_FIRST;
			rd_a_ff <= '0;
			q_int_ff <= '0;
			q_on_ff <= 1'b0;
		end else if (edge_any) begin
			if (tap_v) begin
				rd_busy_ff <= 1'b1;
				rd_i_ff <= qbs_pkg::IDX_FIRST;
				rd_a_ff <= tap_a;
				q_int_ff <= f_w;
				q_on_ff <= 1'b1;
			end else if (rd_busy_ff && (rd_i_ff != qbs_pkg::IDX_LAST)) begin
				rd_i_ff <= f_i;
				q_int_ff <= f_w;
			end else begin
				rd_busy_ff <= 1'b0;
				if (kn_rise) begin
					q_on_ff <= 1'b0;
				end
			end
		end
	end

	// Output stage delayed one more cycle so data and echo line up; the flag, registered only once, leads them
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			rdata <= '0;
			rdata_oe <= 1'b0;
			read_data_valid_flag <= 1'b0;
			echo_clock_out <= 1'b0;
			echo_clock_out_n <= 1'b0;
		end else begin
			rdata <= q_int_ff;
			rdata_oe <= q_on_ff;
			read_data_valid_flag <= tap_v || (rd_busy_ff && (rd_i_ff != qbs_pkg::IDX_LAST));
			echo_clock_out <= kp_d_ff;
			echo_clock_out_n <= kn_d_ff;
		end
	end

	// Write side: first word on the positive rise after the request
	assign cap_first = k_rise && req_on_ff;
	assign cap = edge_any && (cap_first || col_on_ff);
	assign cap_i = cap_first ? qbs_pkg::IDX_FIRST : col_i_ff;
	assign commit = cap && (cap_i == qbs_pkg::IDX_LAST);

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			req_on_ff <= 1'b0;
			req_a_ff <= '0;
			col_on_ff <= 1'b0;
			col_i_ff <= qbs_pkg::IDX_FIRST;
			col_a_ff <= '0;
			for (int i = 0; i < qbs_pkg::BURST; i++) begin
				col_d_ff[i] <= '0;
				col_m_ff[i] <= '1;
			end
		end else begin
			if (k_rise) begin
				req_on_ff <= acc_wr;
				if (acc_wr) begin
					req_a_ff <= a_s;
				end
			end
			if (cap) begin
				col_d_ff[cap_i] <= d_s;
				col_m_ff[cap_i] <= bws_s;
				col_i_ff <= qbs_pkg::IDX_W'(cap_i + 1'b1);
				col_on_ff <= !commit;
				if (cap_first) begin
					col_a_ff <= req_a_ff;
				end
			end
		end
	end

	// Last word comes straight from the pins on the commit edge
	always_comb begin
		for (int i = 0; i < qbs_pkg::BURST; i++) begin
			cm_d[i] = col_d_ff[i];
			cm_m[i] = col_m_ff[i];
		end
		cm_d[qbs_pkg::IDX_LAST] = d_s;
		cm_m[qbs_pkg::IDX_LAST] = bws_s;
	end

	// One array per burst position, each half guarded by its own select
	always_ff @(posedge sys_clk) begin
		if (commit) begin
			for (int i = 0; i < qbs_pkg::BURST; i++) begin
				if (!cm_m[i][qbs_pkg::BWS_LO]) begin
					mem_lo[i][col_a_ff] <= cm_d[i][qbs_pkg::HALF_W-1:0];
				end
				if (!cm_m[i][qbs_pkg::BWS_HI]) begin
					mem_hi[i][col_a_ff] <= cm_d[i][qbs_pkg::DATA_W-1:qbs_pkg::HALF_W];
				end
			end
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	sequence s_burst_start;
		edge_any && tap_v;
	endsequence

	sequence s_first_word;
		q_on_ff && (rd_i_ff == qbs_pkg::IDX_FIRST) ##1 rdata_oe;
	endsequence

	sequence s_word_step;
		edge_any && !tap_v && rd_busy_ff && (rd_i_ff != qbs_pkg::IDX_LAST);
	endsequence

	sequence s_next_word;
		q_on_ff && (rd_i_ff == $past(rd_i_ff) + 2'h1);
	endsequence

	sequence s_both_from_idle;
		k_rise && !rps_s && !wps_s && (last_op_ff != qbs_pkg::OP_READ);
	endsequence

	sequence s_full_burst;
		kn_rise && col_on_ff && (col_i_ff == qbs_pkg::IDX_LAST);
	endsequence

	burst_start_a: assert property (s_burst_start |=> s_first_word)
		else $error("burst did not start with the lowest word");

	word_step_a: assert property (s_word_step |=> s_next_word)
		else $error("burst word index did not advance");

	float_kn_a: assert property ($fell(q_on_ff) |-> $past(kn_rise) && !$past(tap_v))
		else $error("outputs floated off a negative rise or mid burst");

	start_pos_a: assert property (acc_rd || acc_wr |-> k_rise && !(acc_rd && acc_wr))
		else $error("access started off a positive rise");

	no_rd_pair_a: assert property (acc_rd |-> last_op_ff != qbs_pkg::OP_READ)
		else $error("second consecutive read accepted");

	no_wr_twice_a: assert property (acc_wr |-> last_op_ff != qbs_pkg::OP_WRITE)
		else $error("second consecutive write accepted");

	both_sel_a: assert property (s_both_from_idle |-> acc_rd && !acc_wr)
		else $error("arbitration did not pick the read");

	commit_pos_a: assert property (commit |-> s_full_burst)
		else $error("write committed before four words");

	flag_lead_a: assert property ($rose(rdata_oe) |-> $past(read_data_valid_flag, 2))
		else $error("valid flag did not lead the data");
endmodule
`default_nettype wire

// ### verilog/qbs_sync.sv
`timescale 1ns/1ps
`default_nettype none
module qbs_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout_ff
);
	logic [W-1:0] meta_ff;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			meta_ff <= '0;
			dout_ff <= '0;
		end else begin
			meta_ff <= din;
			dout_ff <= meta_ff;
		end
	end
endmodule
`default_nettype wire
